// *** design/attr_service_pkg.sv ***
// package for the attribute service handler: service codes, error codes,
// request/response carriers and attribute table sizing.
// assumes one synchronous clock domain around every user.
package attr_service_pkg;

  // ==========================================================
  // service codes
  localparam logic [7:0] SVC_READ_SINGLE = 8'h0E;
  localparam logic [7:0] SVC_WRITE_SINGLE = 8'h10;
  localparam logic [7:0] SVC_NEG_RESPONSE = 8'h14;
  localparam logic [7:0] SVC_RESTORE = 8'h15;
  localparam logic [7:0] SVC_SAVE = 8'h16;
  localparam logic [7:0] SVC_NULL_REQUEST = 8'h17;
  localparam logic [7:0] REPLY_BIT = 8'h80;

  // ==========================================================
  // general and additional error codes
  localparam logic [7:0] ERR_RESOURCE = 8'h02;
  localparam logic [7:0] ERR_NOT_SUPPORTED = 8'h08;
  localparam logic [7:0] ERR_INVALID_VALUE = 8'h09;
  localparam logic [7:0] ERR_NOT_SETTABLE = 8'h0E;
  localparam logic [7:0] ERR_ATTR_UNSUPPORTED = 8'h14;
  localparam logic [7:0] ADD_NONE = 8'hFF;

  // ==========================================================
  // attribute table sizing and reset contents
  localparam int ATTR_COUNT = 8;
  localparam logic [7:0] ATTR_RESET = 8'h00;
  localparam logic [7:0] ATTR_LIMIT_DEFAULT = 8'hFF;

  typedef struct packed {
    logic [7:0] service;
    logic [7:0] attribute_selector;
    logic [7:0] value;
  } request_s;

  typedef struct packed {
    logic [7:0] service;
    logic [7:0] general_code;
    logic [7:0] additional_code;
    logic [7:0] value;
    logic has_value;
  } response_s;

endpackage

// *** design/attr_checker.sv ***
// value check for one attribute: bounded by a per-attribute upper limit.
// assumes limit vector is static configuration.
`timescale 1ns/10ps
module attr_checker
  import attr_service_pkg::*;
#(
  parameter int COUNT = ATTR_COUNT
) (
  input wire logic [7:0] selector,
  input wire logic [7:0] value,
  input wire logic [COUNT*8-1:0] limits,
  output logic ok
);
  // selectors are one byte wide
  if (COUNT < 1 || COUNT > 255) begin : g_bad_count
    $error("checker size out of range");
  end

  always_comb begin
    ok = 1'b0;
    for (int i = 0; i < COUNT; i++) begin
      if (selector == 8'(i)) begin
        ok = (value <= limits[i*8 +: 8]);
      end
    end
  end
endmodule // attr_checker

// *** design/attr_store.sv ***
// storage area that save writes and restore reads, with readback check.
// assumes one write per clock and combinational read.
`timescale 1ns/10ps
module attr_store
  import attr_service_pkg::*;
#(
  parameter int COUNT = ATTR_COUNT
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [7:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_idx,
  output logic [7:0] rd_data
);
  // a single slot would leave no index bits to slice
  if (COUNT < 2 || COUNT > 255) begin : g_bad_count
    $error("storage size out of range");
  end

  logic [7:0] mem [COUNT];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < COUNT; i++) begin
        mem[i] <= ATTR_RESET;
      end
    end else if (wr_en && wr_idx < 8'(COUNT)) begin
      mem[wr_idx[$clog2(COUNT)-1:0]] <= wr_data;
    end
  end

  assign rd_data = (rd_idx < 8'(COUNT)) ? mem[rd_idx[$clog2(COUNT)-1:0]] : 8'h00;
endmodule // attr_store

// *** design/attribute_service_handler.sv ***
// attribute service handler: executes single read/write, restore, save
// and null requests on a small attribute table, answering each request.
// assumes requester holds req until req_ready and takes rsp when valid.
// Contract
// - read-single request 0E returns selected attribute's current contents.
// - read-single: error gives negative response, success carries value.
// - write-single 10 checks value first; failed check gives negative response.
// - negative code 14 only appears in responses to received requests.
// - negative data: general error byte then additional code byte.
// - additional code is 255 when no extra detail exists.
// - restore 15 copies storage area into active attributes.
// - restore checks all stored values first; changes only if all pass.
// - failed restore check reports first failing attribute as additional code.
// - other restore errors give negative response.
// - all checks pass: update active attributes, then respond success.
// - save 16 copies active attributes into storage area.
// - save succeeds only after copy done and verified; errors negative.
// - null request 17 only responds, no other internal action.
// - null request succeeds if supported, else negative response.
// - unimplemented service reports general error 08.
// - invalid write or restore value reports general error 09.
`timescale 1ns/10ps
module attribute_service_handler
  import attr_service_pkg::*;
#(
  parameter int COUNT = ATTR_COUNT,
  parameter logic [COUNT-1:0] WRITABLE = '1,
  parameter logic [COUNT*8-1:0] LIMITS = {COUNT{ATTR_LIMIT_DEFAULT}},
  parameter bit NULL_SUPPORTED = 1'b1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic req_valid,
  input wire request_s req,
  output logic req_ready,
  output logic rsp_valid,
  output response_s rsp,
  input wire logic rsp_ready,
  output logic [COUNT*8-1:0] active_attrs
);

  // ==========================================================
  // parameter checks
  // selectors and the scan index are one byte, so 255 attributes at most
  if (COUNT < 2 || COUNT > 255) begin : g_bad_count
    $error("attribute count out of range");
  end

  localparam int IW = $clog2(COUNT);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_VERIFY = 3'b001,
    ST_COPY_IN = 3'b010,
    ST_SAVE = 3'b011,
    ST_SAVE_CHECK = 3'b100,
    ST_REPLY = 3'b101
  } state_e;

  state_e state;
  request_s cur;
  logic [7:0] idx;
  logic [7:0] active [COUNT];
  logic [7:0] store_rd;
  logic store_wr;
  logic [7:0] chk_sel;
  logic [7:0] chk_val;
  logic chk_ok;
  logic last_idx;

  // ==========================================================
  // helpers
  function automatic logic sel_valid(input logic [7:0] sel);
    return sel < 8'(COUNT);
  endfunction

  function automatic logic [7:0] step(input logic [7:0] i);
    return i + 8'h01;
  endfunction

  function automatic response_s neg(input logic [7:0] svc, input logic [7:0] gen,
                                    input logic [7:0] add);
    response_s r;
    r.service = SVC_NEG_RESPONSE;
    r.general_code = gen;
    r.additional_code = add;
    r.value = svc;
    r.has_value = 1'b0;
    return r;
  endfunction

  function automatic response_s ok(input logic [7:0] svc, input logic [7:0] val,
                                   input logic has);
    response_s r;
    r.service = svc | REPLY_BIT;
    r.general_code = 8'h00;
    r.additional_code = 8'h00;
    r.value = val;
    r.has_value = has;
    return r;
  endfunction

  assign last_idx = (idx == 8'(COUNT - 1));
  // handshakes come from the state alone, so neither waits on the other side
  assign req_ready = (state == ST_IDLE);
  assign rsp_valid = (state == ST_REPLY);
  assign store_wr = (state == ST_SAVE);

  // the checker serves the write request and the restore scan in turn
  assign chk_sel = (state == ST_IDLE) ? req.attribute_selector : idx;
  assign chk_val = (state == ST_IDLE) ? req.value : store_rd;

  attr_checker #(
    .COUNT(COUNT)
  ) u_check (
    .selector(chk_sel),
    .value(chk_val),
    .limits(LIMITS),
    .ok(chk_ok)
  );

  attr_store #(
    .COUNT(COUNT)
  ) u_store (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .wr_en(store_wr),
    .wr_idx(idx),
    .wr_data(active[idx[IW-1:0]]),
    .rd_idx(idx),
    .rd_data(store_rd)
  );

  always_comb begin
    for (int i = 0; i < COUNT; i++) begin
      active_attrs[i*8 +: 8] = active[i];
    end
  end

  // ==========================================================
  // sequencer and response
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      cur <= '0;
      rsp <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (req_valid) begin
            cur <= req;
            state <= ST_REPLY;
            case (req.service)
              SVC_READ_SINGLE: begin
                if (sel_valid(req.attribute_selector)) begin
                  rsp <= ok(req.service, active[req.attribute_selector[IW-1:0]], 1'b1);
                end else begin
                  rsp <= neg(req.service, ERR_ATTR_UNSUPPORTED, ADD_NONE);
                end
              end
              SVC_WRITE_SINGLE: begin
                if (!sel_valid(req.attribute_selector)) begin
                  rsp <= neg(req.service, ERR_ATTR_UNSUPPORTED, ADD_NONE);
                end else if (!WRITABLE[req.attribute_selector[IW-1:0]]) begin
                  rsp <= neg(req.service, ERR_NOT_SETTABLE, ADD_NONE);
                end else if (!chk_ok) begin
                  rsp <= neg(req.service, ERR_INVALID_VALUE, ADD_NONE);
                end else begin
                  rsp <= ok(req.service, 8'h00, 1'b0);
                end
              end
              SVC_RESTORE: begin
                state <= ST_VERIFY;
              end
              SVC_SAVE: begin
                state <= ST_SAVE;
              end
              SVC_NULL_REQUEST: begin
                if (NULL_SUPPORTED) begin
                  rsp <= ok(req.service, 8'h00, 1'b0);
                end else begin
                  rsp <= neg(req.service, ERR_NOT_SUPPORTED, ADD_NONE);
                end
              end
              default: begin
                rsp <= neg(req.service, ERR_NOT_SUPPORTED, ADD_NONE);
              end
            endcase
          end
        end
        ST_VERIFY: begin
          if (!chk_ok) begin
            rsp <= neg(cur.service, ERR_INVALID_VALUE, idx);
            state <= ST_REPLY;
          end else if (last_idx) begin
            state <= ST_COPY_IN;
          end
        end
        ST_COPY_IN: begin
          if (last_idx) begin
            rsp <= ok(cur.service, 8'h00, 1'b0);
            state <= ST_REPLY;
          end
        end
        ST_SAVE: begin
          // one cycle for the write, the next for its readback
          state <= ST_SAVE_CHECK;
        end
        ST_SAVE_CHECK: begin
          if (store_rd != active[idx[IW-1:0]]) begin
            rsp <= neg(cur.service, ERR_RESOURCE, idx);
            state <= ST_REPLY;
          end else if (last_idx) begin
            rsp <= ok(cur.service, 8'h00, 1'b0);
            state <= ST_REPLY;
          end else begin
            state <= ST_SAVE;
          end
        end
        ST_REPLY: begin
          if (rsp_ready) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          rsp <= neg(cur.service, ERR_RESOURCE, ADD_NONE);
          state <= ST_REPLY;
        end
      endcase
    end
  end

  // ==========================================================
  // scan index
  // one walker serves the restore check, the restore copy and the save,
  // so every scan starts from attribute zero once the request is taken
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      idx <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          idx <= 8'h00;
        end
        ST_VERIFY: begin
          // a failing attribute keeps its index for the additional code
          if (chk_ok) begin
            idx <= last_idx ? 8'h00 : step(idx);
          end
        end
        ST_COPY_IN: begin
          if (!last_idx) begin
            idx <= step(idx);
          end
        end
        ST_SAVE_CHECK: begin
          if (!last_idx && store_rd == active[idx[IW-1:0]]) begin
            idx <= step(idx);
          end
        end
        default: begin
          idx <= idx;
        end
      endcase
    end
  end

  // ==========================================================
  // active attribute area
  // a write lands on the edge that takes it, so its answer already sees it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < COUNT; i++) begin
        active[i] <= ATTR_RESET;
      end
    end else if (state == ST_IDLE && req_valid && req.service == SVC_WRITE_SINGLE
                 && sel_valid(req.attribute_selector)
                 && WRITABLE[req.attribute_selector[IW-1:0]] && chk_ok) begin
      active[req.attribute_selector[IW-1:0]] <= req.value;
    end else if (state == ST_COPY_IN) begin
      active[idx[IW-1:0]] <= store_rd;
    end
  end

endmodule // attribute_service_handler

// *** test/attr_service_props.sv ***
// checker for the attribute service handler, watching its ports only
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/10ps
module attr_service_props
  import attr_service_pkg::*;
#(
  parameter int COUNT = ATTR_COUNT,
  parameter logic [COUNT*8-1:0] LIMITS = {COUNT{ATTR_LIMIT_DEFAULT}},
  parameter logic [COUNT-1:0] WRITABLE = '1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic req_valid,
  input wire request_s req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire response_s rsp,
  input wire logic rsp_ready,
  input wire logic [COUNT*8-1:0] active_attrs
);
  localparam int SAVE_WAIT = 2*COUNT;
  localparam int LOAD_WAIT = 2*COUNT;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // helpers
  wire logic take = req_valid && req_ready;
  wire logic sel_ok = req.attribute_selector < COUNT;
  wire logic settable = sel_ok && 1'(WRITABLE >> req.attribute_selector);
  wire logic [7:0] cur = 8'(active_attrs >> {req.attribute_selector, 3'b000});
  wire logic [7:0] lim = 8'(LIMITS >> {req.attribute_selector, 3'b000});
  wire logic known = req.service inside {SVC_READ_SINGLE, SVC_WRITE_SINGLE,
    SVC_RESTORE, SVC_SAVE, SVC_NULL_REQUEST};
  // ==========================================================
  // assertions
  chk_read_value: assert property (take && req.service == SVC_READ_SINGLE && sel_ok
    |=> rsp_valid && rsp.service == (SVC_READ_SINGLE | REPLY_BIT) && rsp.value == $past(cur)
    && rsp.has_value) else $error("read answer wrong");
  chk_read_badsel: assert property (take && req.service == SVC_READ_SINGLE && !sel_ok
    |=> rsp_valid && rsp.service == SVC_NEG_RESPONSE && rsp.general_code == ERR_ATTR_UNSUPPORTED
    && rsp.additional_code == ADD_NONE) else $error("bad selector not refused");
  chk_write_apply: assert property (take && req.service == SVC_WRITE_SINGLE && settable
    && req.value <= lim |=> 8'(active_attrs >> {$past(req.attribute_selector), 3'b000})
    == $past(req.value)) else $error("write not applied");
  chk_write_reject: assert property (take && req.service == SVC_WRITE_SINGLE && settable
    && req.value > lim |=> rsp.general_code == ERR_INVALID_VALUE && $stable(active_attrs))
    else $error("invalid write accepted");
  chk_unknown_svc: assert property (take && !known
    |=> rsp_valid && rsp.service == SVC_NEG_RESPONSE && rsp.general_code == ERR_NOT_SUPPORTED
    && rsp.additional_code == ADD_NONE && rsp.value == $past(req.service))
    else $error("unknown service answer wrong");
  chk_null_quiet: assert property (take && req.service == SVC_NULL_REQUEST
    |=> rsp_valid && rsp.service == (SVC_NULL_REQUEST | REPLY_BIT) && $stable(active_attrs))
    else $error("null request misbehaved");
  chk_save_time: assert property (take && req.service == SVC_SAVE
    |=> !rsp_valid ##SAVE_WAIT rsp_valid && rsp.service == (SVC_SAVE | REPLY_BIT))
    else $error("save answer timing wrong");
  chk_restore_time: assert property (take && req.service == SVC_RESTORE
    |=> !rsp_valid ##LOAD_WAIT rsp_valid && rsp.service == (SVC_RESTORE | REPLY_BIT))
    else $error("restore answer timing wrong");
  chk_busy_refuse: assert property (rsp_valid |-> !req_ready)
    else $error("request accepted while answering");
  chk_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
    else $error("response dropped before taken");
  cover property (take && req.service == SVC_SAVE);
  cover property (take && req.service == SVC_RESTORE);
  cover property (rsp_valid && rsp.general_code == ERR_INVALID_VALUE);
endmodule // attr_service_props

bind attribute_service_handler attr_service_props #(.COUNT(COUNT), .LIMITS(LIMITS),
  .WRITABLE(WRITABLE)) props (
  .clk_sys(clk_sys), .nrst(nrst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .rsp(rsp), .rsp_ready(rsp_ready), .active_attrs(active_attrs));

// *** test/attr_client.sv ***
// requesting client model: offers one request, then takes the answer
// assumes req_ready does not depend on req_valid within a cycle
`timescale 1ns/10ps
module attr_client
  import attr_service_pkg::*;
(
  input wire logic clk_sys,
  output logic req_valid,
  output request_s req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire response_s rsp,
  output logic rsp_ready
);
  initial begin
    req_valid = 1'b0;
    req = '0;
    rsp_ready = 1'b0;
  end
  task automatic transact(input request_s r, input int stall, output response_s got);
    logic seen;
    int n;
    n = 0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= r;
    do begin
      @(negedge clk_sys);
      seen = req_ready;
      @(posedge clk_sys);
      n++;
    end while (!seen && n < 200);
    req_valid <= 1'b0;
    // released fields show the inverse so stale data cannot pass
    req <= ~r;
    seen = 1'b0;
    while (!(seen && rsp_ready) && n < 400) begin
      @(negedge clk_sys);
      seen = rsp_valid;
      got = rsp;
      @(posedge clk_sys);
      n++;
      if (seen && !rsp_ready && stall-- == 0) rsp_ready <= 1'b1;
    end
    rsp_ready <= 1'b0;
  endtask
endmodule // attr_client

// *** test/attribute_service_handler_tb.sv ***
// self-checking bench: random requests plus corner cases, model of attributes
// assumes the client model drives every request input of the handler
`timescale 1ns/10ps
module attribute_service_handler_tb
  import attr_service_pkg::*;
;
  localparam int N = ATTR_COUNT;
  localparam logic [N*8-1:0] LIM = {N{8'hC0}};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic req_valid, req_ready, rsp_valid, rsp_ready;
  request_s req;
  response_s rsp;
  logic [N*8-1:0] active_attrs;
  logic [7:0] act [N] = '{default: 8'h00};
  logic [7:0] saved [N] = '{default: 8'h00};
  logic [7:0] codes [9] = '{8'h0E, 8'h10, 8'h14, 8'h15, 8'h16, 8'h17, 8'h01, 8'h0F, 8'h18};
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;

  attribute_service_handler #(.LIMITS(LIM)) uut (.clk_sys(clk_sys), .nrst(nrst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp(rsp), .rsp_ready(rsp_ready), .active_attrs(active_attrs));
  attr_client client (.clk_sys(clk_sys), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .rsp_ready(rsp_ready));

  initial forever #2 clk_sys = ~clk_sys;

  // ==========================================================
  // checking and expectations
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] exp_general(logic [7:0] s, logic [7:0] a, logic [7:0] v);
    if ((s == SVC_READ_SINGLE || s == SVC_WRITE_SINGLE) && a >= N) return ERR_ATTR_UNSUPPORTED;
    if (s == SVC_WRITE_SINGLE && v > LIM[a*8+:8]) return ERR_INVALID_VALUE;
    if (!(s inside {8'h0E, 8'h10, 8'h15, 8'h16, 8'h17})) return ERR_NOT_SUPPORTED;
    return 8'h00;
  endfunction

  task automatic op(input logic [7:0] s, input logic [7:0] a, input logic [7:0] v);
    response_s got;
    logic [7:0] g;
    g = exp_general(s, a, v);
    client.transact('{s, a, v}, $urandom_range(0, 2), got);
    check("general", got.general_code, g);
    if (g != 8'h00) begin
      check("service", got.service, SVC_NEG_RESPONSE);
      check("additional", got.additional_code, ADD_NONE);
      check("echo", got.value, s);
    end else begin
      check("service", got.service, s | REPLY_BIT);
      check("has_value", got.has_value, s == SVC_READ_SINGLE);
      if (s == SVC_READ_SINGLE) check("value", got.value, act[a]);
      if (s == SVC_WRITE_SINGLE) act[a] = v;
      if (s == SVC_SAVE) saved = act;
      if (s == SVC_RESTORE) act = saved;
    end
    for (int i = 0; i < N; i++) check("attr", active_attrs[i*8+:8], act[i]);
  endtask

  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // sequence
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    void'($urandom(32'h48f923f3));
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    // limit boundary, bad selector, save then clobber then restore
    op(SVC_READ_SINGLE, 8'h00, 8'h00);
    op(SVC_WRITE_SINGLE, 8'h07, 8'hC0);
    op(SVC_WRITE_SINGLE, 8'h07, 8'hC1);
    op(SVC_READ_SINGLE, 8'h07, 8'h00);
    op(SVC_READ_SINGLE, 8'h08, 8'h00);
    op(SVC_SAVE, 8'h00, 8'h00);
    op(SVC_WRITE_SINGLE, 8'h07, 8'h11);
    op(SVC_RESTORE, 8'h00, 8'h00);
    op(SVC_NULL_REQUEST, 8'h00, 8'h00);
    for (int i = 0; i < 300; i++) begin
      op(codes[$urandom_range(0, 8)], 8'($urandom_range(0, N + 1)), 8'($urandom));
    end
    test_done();
  end
endmodule // attribute_service_handler_tb
